// *** design/lbr_pkg.sv ***
// Constants for the long conditional branch unit
// Function
// - Higher-same: carry clear loads pc+4+offset
// - Carry-clear alias shares opcode and test
// - Encoding: prefix 18, opcode 24, two offsets
// - Queue refill four taken, three not
// - Greater 2E, greater-eq 2C signed tests
// - Less-eq 2F, less 2D signed tests
// - Unsigned 22,23,24,25 on carry and zero
// - Simple 26..2B on zero, negative, overflow
// - Always 20 taken, never 21 not
// - Flags never changed by long branch
package lbr_pkg;
	localparam logic [7:0]  PREFIX_BYTE           = 8'h18;
	localparam logic [7:0]  OP_LBR_ALWAYS         = 8'h20;
	localparam logic [7:0]  OP_LBR_NEVER          = 8'h21;
	localparam logic [7:0]  OP_LBR_UNSIGNED_HIGHER = 8'h22;
	localparam logic [7:0]  OP_LBR_LOWER_SAME     = 8'h23;
	localparam logic [7:0]  OP_LBR_HIGHER_SAME    = 8'h24;
	localparam logic [7:0]  OP_LBR_CARRY_CLEAR    = 8'h24;
	localparam logic [7:0]  OP_LBR_UNSIGNED_LOWER = 8'h25;
	localparam logic [7:0]  OP_LBR_CARRY_SET      = 8'h25;
	localparam logic [7:0]  OP_LBR_NOT_EQUAL      = 8'h26;
	localparam logic [7:0]  OP_LBR_EQUAL          = 8'h27;
	localparam logic [7:0]  OP_LBR_OVERFLOW_CLEAR = 8'h28;
	localparam logic [7:0]  OP_LBR_OVERFLOW_SET   = 8'h29;
	localparam logic [7:0]  OP_LBR_PLUS           = 8'h2A;
	localparam logic [7:0]  OP_LBR_MINUS          = 8'h2B;
	localparam logic [7:0]  OP_LBR_SIGNED_GREATER_EQ = 8'h2C;
	localparam logic [7:0]  OP_LBR_SIGNED_LESS    = 8'h2D;
	localparam logic [7:0]  OP_LBR_SIGNED_GREATER = 8'h2E;
	localparam logic [7:0]  OP_LBR_SIGNED_LESS_EQ = 8'h2F;
	localparam logic [15:0] PC_STEP               = 16'h0004;
	localparam logic [15:0] PC_RESET              = 16'h0000;
	localparam logic [2:0]  REFILL_TAKEN          = 3'h4;
	localparam logic [2:0]  REFILL_NOT_TAKEN      = 3'h3;
	// Flag positions in the 8-bit condition_flags byte
	localparam int          FLAG_C                = 0;
	localparam int          FLAG_V                = 1;
	localparam int          FLAG_Z                = 2;
	localparam int          FLAG_N                = 3;
	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_OPCODE = 5'b00010,
		ST_OFS_HI = 5'b00100,
		ST_OFS_LO = 5'b01000,
		ST_REFILL = 5'b10000
	} dec_state_e;
endpackage

// *** design/lbr_cond_eval.sv ***
// Condition evaluation for the long branch opcode map
`timescale 1ns/1ps
`default_nettype none
module lbr_cond_eval
	import lbr_pkg::*;
(
	input  wire logic [7:0] opcode_i,
	input  wire logic [7:0] flags_i,
	output logic            valid_o,
	output logic            taken_o
);
	wire c_w = flags_i[FLAG_C];
	wire v_w = flags_i[FLAG_V];
	wire z_w = flags_i[FLAG_Z];
	wire n_w = flags_i[FLAG_N];
	wire nv_w = n_w ^ v_w;
	// Upper nibble picks the long branch family
	assign valid_o = (opcode_i[7:4] == 4'h2);
	always_comb begin
		case (opcode_i)
			OP_LBR_ALWAYS:            taken_o = 1'b1;
			OP_LBR_NEVER:             taken_o = 1'b0;
			OP_LBR_UNSIGNED_HIGHER:   taken_o = ~(c_w | z_w);
			OP_LBR_LOWER_SAME:        taken_o = c_w | z_w;
			OP_LBR_HIGHER_SAME:       taken_o = ~c_w;
			OP_LBR_UNSIGNED_LOWER:    taken_o = c_w;
			OP_LBR_NOT_EQUAL:         taken_o = ~z_w;
			OP_LBR_EQUAL:             taken_o = z_w;
			OP_LBR_OVERFLOW_CLEAR:    taken_o = ~v_w;
			OP_LBR_OVERFLOW_SET:      taken_o = v_w;
			OP_LBR_PLUS:              taken_o = ~n_w;
			OP_LBR_MINUS:             taken_o = n_w;
			OP_LBR_SIGNED_GREATER_EQ: taken_o = ~nv_w;
			OP_LBR_SIGNED_LESS:       taken_o = nv_w;
			OP_LBR_SIGNED_GREATER:    taken_o = ~(z_w | nv_w);
			OP_LBR_SIGNED_LESS_EQ:    taken_o = z_w | nv_w;
			default:                  taken_o = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// *** design/long_cond_branch_unit.sv ***
// Long conditional branch decoder, program counter update and refill timing
`timescale 1ns/1ps
`default_nettype none
module long_cond_branch_unit
	import lbr_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        byte_valid_i,
	input  wire logic [7:0]  byte_i,
	input  wire logic [7:0]  condition_flags_i,
	input  wire logic [15:0] program_counter_i,
	output logic [15:0]      program_counter_o,
	output logic             pc_load_o,
	output logic             done_o,
	output logic             taken_o,
	output logic [2:0]       refill_cycles_o,
	output logic             busy_o,
	output logic             illegal_o,
	output logic [7:0]       condition_flags_o
);
	import lbr_pkg::*;

	dec_state_e       state_r;
	dec_state_e       state_nxt;
	logic [7:0]       opcode_r;
	logic [7:0]       ofs_hi_r;
	logic [15:0]      base_pc_r;
	logic             taken_r;
	logic [2:0]       refill_cnt_r;
	logic [15:0]      program_counter_r;
	logic             pc_load_r;
	logic             done_r;
	logic [2:0]       refill_cycles_r;
	logic             illegal_r;
	logic [7:0]       flags_r;
	logic             busy_r;

	wire              cond_valid_w;
	wire              cond_taken_w;
	wire              is_prefix_w = byte_valid_i && (byte_i == PREFIX_BYTE);
	wire              op_byte_w   = (state_r == ST_OPCODE) && byte_valid_i;
	wire              lo_byte_w   = (state_r == ST_OFS_LO) && byte_valid_i;
	// First offset byte is the high byte of the displacement
	wire [15:0]       disp_w      = {ofs_hi_r, byte_i};
	// 16-bit wrap matches the address space; no sign extension needed past 16 bits
	wire [15:0]       target_w    = base_pc_r + PC_STEP + disp_w;
	wire              refill_end_w = (state_r == ST_REFILL) && (refill_cnt_r == 3'h1);

	lbr_cond_eval u_cond (
		.opcode_i (byte_i),
		.flags_i  (condition_flags_i),
		.valid_o  (cond_valid_w),
		.taken_o  (cond_taken_w)
	);

	always_comb begin
		case (state_r)
			ST_IDLE:   state_nxt = is_prefix_w ? ST_OPCODE : ST_IDLE;
			ST_OPCODE: state_nxt = !byte_valid_i ? ST_OPCODE :
				(cond_valid_w ? ST_OFS_HI : ST_IDLE);
			ST_OFS_HI: state_nxt = byte_valid_i ? ST_OFS_LO : ST_OFS_HI;
			ST_OFS_LO: state_nxt = byte_valid_i ? ST_REFILL : ST_OFS_LO;
			ST_REFILL: state_nxt = refill_end_w ? ST_IDLE : ST_REFILL;
			default:   state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r   <= ST_IDLE;
			opcode_r  <= 8'h00;
			ofs_hi_r  <= 8'h00;
			base_pc_r <= PC_RESET;
			taken_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (is_prefix_w && state_r == ST_IDLE)
				base_pc_r <= program_counter_i;
			if (op_byte_w) begin
				opcode_r <= byte_i;
				// Flags sampled at the opcode byte, the branch's decision point
				taken_r  <= cond_taken_w;
			end
			if ((state_r == ST_OFS_HI) && byte_valid_i)
				ofs_hi_r <= byte_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			refill_cnt_r    <= 3'h0;
			refill_cycles_r <= 3'h0;
			program_counter_r <= PC_RESET;
			pc_load_r       <= 1'b0;
		end else begin
			pc_load_r <= 1'b0;
			if (lo_byte_w) begin
				refill_cnt_r    <= taken_r ? REFILL_TAKEN : REFILL_NOT_TAKEN;
				refill_cycles_r <= taken_r ? REFILL_TAKEN : REFILL_NOT_TAKEN;
				// Not taken continues at the next instruction, four bytes on
				program_counter_r <= taken_r ? target_w : base_pc_r + PC_STEP;
				pc_load_r       <= taken_r;
			end else if (state_r == ST_REFILL) begin
				refill_cnt_r <= refill_cnt_r - 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_r    <= 1'b0;
			illegal_r <= 1'b0;
			flags_r   <= 8'h00;
			busy_r    <= 1'b0;
		end else begin
			// Busy kept as a flop so the port carries no decode glitch
			busy_r    <= (state_nxt != ST_IDLE);
			done_r    <= refill_end_w;
			illegal_r <= op_byte_w && !cond_valid_w;
			// Flags pass through untouched
			flags_r   <= condition_flags_i;
		end
	end

	assign program_counter_o = program_counter_r;
	assign pc_load_o         = pc_load_r;
	assign done_o            = done_r;
	assign taken_o           = taken_r;
	assign refill_cycles_o   = refill_cycles_r;
	assign busy_o            = busy_r;
	assign illegal_o         = illegal_r;
	assign condition_flags_o = flags_r;

	property p_hs_taken;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_HIGHER_SAME && !condition_flags_i[FLAG_C]
			|=> taken_r;
	endproperty
	a_hs_taken: assert property (p_hs_taken) else $error("higher-same not taken");
	property p_cc_same;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_CARRY_CLEAR && condition_flags_i[FLAG_C] |=> !taken_r;
	endproperty
	a_cc_same: assert property (p_cc_same) else $error("carry-clear taken on carry");
	property p_prefix;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		state_r == ST_IDLE && is_prefix_w |=> state_r == ST_OPCODE;
	endproperty
	a_prefix: assert property (p_prefix) else $error("prefix not decoded");
	property p_refill;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		lo_byte_w && taken_r |=> ##4 done_r;
	endproperty
	a_refill: assert property (p_refill) else $error("taken refill not four");
	property p_refill_nt;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		lo_byte_w && !taken_r |=> ##3 done_r;
	endproperty
	a_refill_nt: assert property (p_refill_nt) else $error("not-taken refill not three");
	property p_gt;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_SIGNED_GREATER |=>
			taken_r == !($past(condition_flags_i[FLAG_Z]) |
			($past(condition_flags_i[FLAG_N]) ^ $past(condition_flags_i[FLAG_V])));
	endproperty
	a_gt: assert property (p_gt) else $error("signed greater wrong");
	property p_lt;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_SIGNED_LESS |=>
			taken_r == ($past(condition_flags_i[FLAG_N]) ^ $past(condition_flags_i[FLAG_V]));
	endproperty
	a_lt: assert property (p_lt) else $error("signed less wrong");
	property p_never;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_NEVER |=> !taken_r;
	endproperty
	a_never: assert property (p_never) else $error("never branch taken");
	property p_target;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		lo_byte_w && taken_r |=> pc_load_r &&
			program_counter_r == $past(base_pc_r) + PC_STEP + {$past(ofs_hi_r), $past(byte_i)};
	endproperty
	a_target: assert property (p_target) else $error("branch target wrong");
	property p_flags;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		busy_o |=> condition_flags_o == $past(condition_flags_i);
	endproperty
	a_flags: assert property (p_flags) else $error("flags altered");
	property p_always;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_ALWAYS |=> taken_r;
	endproperty
	a_always: assert property (p_always) else $error("always branch not taken");
	property p_hi;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_UNSIGNED_HIGHER |=>
			taken_r == !($past(condition_flags_i[FLAG_C]) | $past(condition_flags_i[FLAG_Z]));
	endproperty
	a_hi: assert property (p_hi) else $error("unsigned higher wrong");
	property p_ls;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_LOWER_SAME |=>
			taken_r == ($past(condition_flags_i[FLAG_C]) | $past(condition_flags_i[FLAG_Z]));
	endproperty
	a_ls: assert property (p_ls) else $error("lower-same wrong");
	property p_lo;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_UNSIGNED_LOWER |=>
			taken_r == $past(condition_flags_i[FLAG_C]);
	endproperty
	a_lo: assert property (p_lo) else $error("unsigned lower wrong");
	property p_eq;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_EQUAL |=>
			taken_r == $past(condition_flags_i[FLAG_Z]);
	endproperty
	a_eq: assert property (p_eq) else $error("equal branch wrong");
	property p_ge;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_SIGNED_GREATER_EQ |=>
			taken_r == !($past(condition_flags_i[FLAG_N]) ^ $past(condition_flags_i[FLAG_V]));
	endproperty
	a_ge: assert property (p_ge) else $error("signed greater-eq wrong");
	property p_le;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && byte_i == OP_LBR_SIGNED_LESS_EQ |=>
			taken_r == ($past(condition_flags_i[FLAG_Z]) |
			($past(condition_flags_i[FLAG_N]) ^ $past(condition_flags_i[FLAG_V])));
	endproperty
	a_le: assert property (p_le) else $error("signed less-eq wrong");
	property p_nt_pc;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		lo_byte_w && !taken_r |=> !pc_load_r &&
			program_counter_r == $past(base_pc_r) + PC_STEP;
	endproperty
	a_nt_pc: assert property (p_nt_pc) else $error("not-taken next address wrong");
	property p_illegal;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		op_byte_w && !cond_valid_w |=> illegal_r && state_r == ST_IDLE;
	endproperty
	a_illegal: assert property (p_illegal) else $error("bad opcode not refused");

	c_taken: cover property (@(posedge core_clk_i) lo_byte_w && taken_r);
	c_not_taken: cover property (@(posedge core_clk_i) lo_byte_w && !taken_r);
	c_illegal: cover property (@(posedge core_clk_i) illegal_r);
	c_hs_taken: cover property (@(posedge core_clk_i)
		op_byte_w && byte_i == OP_LBR_HIGHER_SAME && cond_taken_w);
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking testbench for the long conditional branch unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lbr_pkg::*;
	typedef struct {logic ill; logic tk; logic [15:0] pc; logic [2:0] rf;} note_s;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        byte_valid_i = 1'b0;
	logic [7:0]  byte_i = 8'h00;
	logic [7:0]  condition_flags_i = 8'h00;
	logic [15:0] program_counter_i = 16'h0000;
	logic [15:0] program_counter_o;
	logic        pc_load_o;
	logic        done_o;
	logic        taken_o;
	logic [2:0]  refill_cycles_o;
	logic        busy_o;
	logic        illegal_o;
	logic [7:0]  condition_flags_o;
	note_s       q[$];
	note_s       m;
	int          n_errors = 0;
	int          num_checks = 0;
	logic [7:0]  prev_f;
	logic [1:0]  ok_sh = 2'b00;
	logic        seen_ld = 1'b0;
	logic [15:0] dtab[4] = '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000};
	logic [7:0]  bad[5] = '{8'h00, 8'h1F, 8'h30, 8'hFF, 8'h18};

	always #5 core_clk_i = ~core_clk_i;

	long_cond_branch_unit uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.byte_valid_i(byte_valid_i), .byte_i(byte_i), .condition_flags_i(condition_flags_i),
		.program_counter_i(program_counter_i), .program_counter_o(program_counter_o),
		.pc_load_o(pc_load_o), .done_o(done_o), .taken_o(taken_o),
		.refill_cycles_o(refill_cycles_o), .busy_o(busy_o), .illegal_o(illegal_o),
		.condition_flags_o(condition_flags_o));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Reference decision, written apart from the design on purpose
	function automatic logic cond(input logic [7:0] op, input logic [7:0] f);
		logic c, v, z, n;
		c = f[FLAG_C];
		v = f[FLAG_V];
		z = f[FLAG_Z];
		n = f[FLAG_N];
		case (op[3:0])
			4'h0: cond = 1'b1;
			4'h1: cond = 1'b0;
			4'h2: cond = !(c | z);
			4'h3: cond = c | z;
			4'h4: cond = !c;
			4'h5: cond = c;
			4'h6: cond = !z;
			4'h7: cond = z;
			4'h8: cond = !v;
			4'h9: cond = v;
			4'hA: cond = !n;
			4'hB: cond = n;
			4'hC: cond = !(n ^ v);
			4'hD: cond = n ^ v;
			4'hE: cond = !(z | (n ^ v));
			default: cond = z | (n ^ v);
		endcase
	endfunction

	// Random idle gaps, with junk on the byte lane, test that only valid bytes count
	task automatic put(input logic [7:0] b);
		if ($urandom_range(3) == 0) begin
			@(posedge core_clk_i);
			#1;
			byte_valid_i = 1'b0;
			byte_i = 8'($urandom);
		end
		@(posedge core_clk_i);
		#1;
		byte_valid_i = 1'b1;
		byte_i = b;
	endtask

	task automatic branch(input logic [7:0] op, input logic [15:0] d, input bit junk);
		note_s n;
		int k;
		condition_flags_i = 8'($urandom);
		program_counter_i = 16'($urandom);
		n.ill = (op[7:4] != 4'h2);
		n.tk = cond(op, condition_flags_i);
		n.pc = program_counter_i + 16'h0004 + (n.tk ? d : 16'h0000);
		n.rf = n.tk ? 3'h4 : 3'h3;
		q.push_back(n);
		put(8'h18);
		put(op);
		if (!n.ill) begin
			put(d[15:8]);
			put(d[7:0]);
		end
		// A prefix offered during refill must not start a new sequence
		for (k = 0; k < 2 && junk; k++) begin
			@(posedge core_clk_i);
			#1;
			byte_i = 8'h18;
		end
		@(posedge core_clk_i);
		#1;
		byte_valid_i = 1'b0;
		for (k = 0; k < 20 && (busy_o || q.size() != 0); k++) @(posedge core_clk_i);
		#1;
		chk(busy_o, 1'b0);
	endtask

	always @(posedge core_clk_i) prev_f <= condition_flags_i;

	// Outputs launch on the rising edge; reading them on the falling one avoids the race
	always @(negedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ok_sh = 2'b00;
			seen_ld = 1'b0;
		end else begin
			if (ok_sh == 2'b11) chk(condition_flags_o, prev_f);
			ok_sh = {ok_sh[0], 1'b1};
			if (pc_load_o) seen_ld = 1'b1;
			if (done_o || illegal_o) begin
				if (q.size() == 0) chk(1'b1, 1'b0);
				else begin
					m = q.pop_front();
					chk(illegal_o, m.ill);
					if (done_o) begin
						chk(program_counter_o, m.pc);
						chk(taken_o, m.tk);
						chk(refill_cycles_o, m.rf);
						chk(seen_ld, m.tk);
					end
					seen_ld = 1'b0;
				end
			end
		end
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		n_errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		complete_run();
	end

	initial begin
		void'($urandom(80270));
		repeat (3) @(posedge core_clk_i);
		#1;
		rst_n_i = 1'b1;
		for (int i = 0; i < 64; i++) begin
			branch(8'(8'h20 + i[3:0]), (i < 16) ? dtab[i[1:0]] : 16'($urandom), i[3:0] == 4'h5);
		end
		$display("test opcode map done");
		foreach (bad[j]) branch(bad[j], 16'h0000, 1'b0);
		put(8'h24);
		put(8'h00);
		@(posedge core_clk_i);
		#1;
		byte_valid_i = 1'b0;
		chk(busy_o, 1'b0);
		$display("test bad opcodes done");
		put(8'h18);
		put(8'h2E);
		@(posedge core_clk_i);
		#1;
		rst_n_i = 1'b0;
		byte_valid_i = 1'b0;
		#1;
		chk(busy_o, 1'b0);
		chk(program_counter_o, 16'h0000);
		repeat (2) @(posedge core_clk_i);
		#1;
		rst_n_i = 1'b1;
		branch(8'h24, 16'h8000, 1'b1);
		chk(16'(q.size()), 16'h0000);
		$display("test reset mid-sequence done");
		complete_run();
	end
endmodule
`default_nettype wire
